// ===== dv/adcsq_analog_model.sv
// Behavioural analog front end: channel levels, comparator and port pins.
`timescale 1ns/1ps
module adcsq_analog_model (
   // Clock and channel levels, channel 0 in the low byte.
   input  wire logic        mclk,
   input  wire logic [47:0] levels,
   // Converter side.
   input  wire logic [7:0]  dac_code,
   input  wire logic [4:0]  mux_select,
   input  wire logic        select_reference_high,
   input  wire logic        select_reference_low,
   input  wire logic        converter_power_on,
   output logic             comparator_above,
   // Port pins, all held high from outside.
   output logic      [5:0]  port_pin_in
);
   logic       flip = 1'b0;
   logic [7:0] vin;
   always_comb begin
      if (select_reference_high) vin = 8'hff;
      else if (select_reference_low) vin = 8'h00;
      else if (mux_select <= 5'h05) vin = levels[mux_select*8 +: 8];
      else vin = {8{flip}};
   end
   // powered off core toggles, so a result taken while off cannot look valid.
   always @(posedge mclk) flip <= ~flip;
   assign comparator_above = converter_power_on ? (vin >= dac_code) : flip;
   assign port_pin_in = 6'h3f;
endmodule

// ===== dv/adcsq_sva.sv
// Concurrent checks on the converter sequencing control ports.
`timescale 1ns/1ps
module adcsq_sva (
   // Clock, reset, bus and system.
   input wire logic        mclk,
   input wire logic        reset,
   input wire logic [3:0]  paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        stop_mode,
   // Watched outputs.
   input wire logic        sample_hold,
   input wire logic        converter_power_on,
   input wire logic [4:0]  mux_select,
   input wire logic        select_reference_high,
   input wire logic [5:0]  analog_pin_claim,
   input wire logic [5:0]  port_read_data,
   input wire logic        conversion_irq
);
   // ---------------------------------------------------------------
   // Helpers and checks.
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   logic       rd_res;
   logic       wr_sc;
   logic       held;
   logic [4:0] m1;
   logic [4:0] m2;
   // Channel outputs may lag the channel, so they are judged once it has settled.
   always_ff @(posedge mclk) begin
      m1 <= mux_select;
      m2 <= m1;
   end
   // Completed accesses that carry side effects.
   assign rd_res = psel && penable && pready && !pwrite && paddr == adcsq_pkg::OFF_RESULT;
   assign wr_sc = psel && penable && pready && pwrite && paddr == adcsq_pkg::OFF_STATUS_CONTROL;
   assign held = mux_select == m1 && m1 == m2;
   chk_irq_read_clr: assert property (rd_res |=> !conversion_irq)
      else $error("Interrupt stayed up after a result read.");
   chk_irq_write_clr: assert property (wr_sc |=> !conversion_irq)
      else $error("Interrupt stayed up after a control write.");
   chk_write_starts: assert property (wr_sc && pwdata[4:0] != 5'h1f && !stop_mode
      |-> ##[1:3] sample_hold)
      else $error("Control write did not start a sample.");
   chk_off_code: assert property (mux_select == 5'h1f && m1 == 5'h1f
      |-> !converter_power_on)
      else $error("Converter powered while the off code is selected.");
   chk_ref_high: assert property (held |-> select_reference_high == (mux_select == 5'h1d))
      else $error("High reference select disagrees with the channel.");
   chk_pin_claim: assert property (held |-> analog_pin_claim ==
      (mux_select <= 5'h05 ? 6'h01 << mux_select : 6'h00))
      else $error("Claimed pin does not match the channel.");
   chk_pin_reads_0: assert property ($stable(analog_pin_claim)
      |-> (port_read_data & analog_pin_claim) == 6'h00)
      else $error("Claimed pin does not read as zero.");
   chk_stop_idle: assert property (stop_mode [*3]
      |-> !sample_hold && !$rose(conversion_irq))
      else $error("Converter active during stop.");
   cov_irq: cover property ($rose(conversion_irq));
   cov_stop_exit: cover property (stop_mode ##1 !stop_mode);
   cov_ref_high: cover property (select_reference_high);
endmodule

bind adcsq_top adcsq_sva u_sva (.mclk, .reset, .paddr, .psel, .penable, .pwrite, .pwdata,
   .pready, .stop_mode, .sample_hold, .converter_power_on, .mux_select,
   .select_reference_high, .analog_pin_claim, .port_read_data, .conversion_irq);

// ===== dv/tb_adcsq_top.sv
// Self-checking bench for the converter sequencing control block.
`timescale 1ns/1ps
module tb_adcsq_top;
   // ---------------------------------------------------------------
   // Stimulus, design and analog model.
   // ---------------------------------------------------------------
   localparam logic [3:0] A_SC = adcsq_pkg::OFF_STATUS_CONTROL;
   localparam logic [3:0] A_RS = adcsq_pkg::OFF_RESULT;
   localparam logic [3:0] A_CK = adcsq_pkg::OFF_CLOCK_SELECT;
   logic        mclk = 1'b0;
   logic        reset = 1'b1;
   logic [3:0]  paddr = 4'h0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic        stop_mode = 1'b0;
   logic [2:0]  osc = 3'h0;
   logic [47:0] levels = 48'h3c_96_5a_c3_69_a5;
   logic [31:0] prdata, r;
   logic [7:0]  dac_code;
   logic [4:0]  mux_select;
   logic [5:0]  port_pin_in, analog_pin_claim, port_read_data;
   logic        pready, pslverr, err, comparator_above, sample_hold, converter_power_on;
   logic        select_reference_high, select_reference_low, conversion_irq;
   int          n_fail = 0;
   int          total_checks = 0;
   int          cyc = 0;
   int          n;
   int          div;
   adcsq_top uut (.mclk, .reset, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .stop_mode, .oscillator_clock(osc[2]), .comparator_above, .dac_code,
      .sample_hold, .converter_power_on, .mux_select, .select_reference_high,
      .select_reference_low, .port_pin_in, .analog_pin_claim, .port_read_data,
      .conversion_irq);
   adcsq_analog_model u_model (.mclk, .levels, .dac_code, .mux_select, .select_reference_high,
      .select_reference_low, .converter_power_on, .comparator_above, .port_pin_in);
   // Bus clock.
   initial forever #2 mclk = ~mclk;
   // Oscillator at one eighth of mclk, and the hang limit.
   always @(posedge mclk) begin
      osc <= osc + 3'h1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         results();
      end
   end
   // One APB transfer; the request holds until pready is seen at an edge.
   task automatic apb(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Count cycles until the interrupt request shows; the hang limit bounds it.
   task automatic irqwait();
      n = 0;
      while (conversion_irq !== 1'b1) begin
         @(posedge mclk);
         n++;
      end
   endtask
   task automatic t_reset();
      apb(0, A_SC, 8'h0);
      chk(r, 32'h1f);
      apb(1, A_RS, 8'hff);
      apb(0, A_RS, 8'h0);
      chk(r, 32'h0);
      apb(1, 4'hc, 8'hff);
      chk({31'h0, err}, 32'h1);
      apb(0, A_CK, 8'h0);
      chk(r, 32'h0);
      $display("t_reset done");
   endtask
   task automatic t_single();
      apb(1, A_CK, 8'h50);
      apb(1, A_SC, 8'h00);
      repeat (20) @(posedge mclk);
      apb(1, A_SC, 8'h02);
      repeat (4) @(posedge mclk);
      chk({26'h0, analog_pin_claim}, 32'h04);
      chk({26'h0, port_read_data}, 32'h3b);
      do apb(0, A_SC, 8'h0); while (r[7] !== 1'b1);
      chk(r, 32'h82);
      apb(0, A_RS, 8'h0);
      chk(r, {24'h0, levels[23:16]});
      repeat (150) @(posedge mclk);
      apb(0, A_SC, 8'h0);
      chk(r, 32'h02);
      $display("t_single done");
   endtask
   task automatic t_irq();
      apb(1, A_SC, 8'h43);
      irqwait();
      apb(0, A_SC, 8'h0);
      chk(r, 32'h43);
      apb(0, A_RS, 8'h0);
      chk(r, {24'h0, levels[31:24]});
      @(posedge mclk);
      chk({31'h0, conversion_irq}, 32'h0);
      for (int i = 0; i < 2; i++) begin
         apb(1, A_SC, i ? 8'h5e : 8'h5d);
         irqwait();
         apb(0, A_RS, 8'h0);
         chk(r, i ? 32'h0 : 32'hff);
      end
      apb(1, A_SC, 8'h44);
      irqwait();
      apb(1, A_SC, 8'h5f);
      repeat (2) @(posedge mclk);
      chk({31'h0, conversion_irq}, 32'h0);
      chk({31'h0, converter_power_on}, 32'h0);
      $display("t_irq done");
   endtask
   task automatic t_cont();
      apb(1, A_SC, 8'h24);
      do apb(0, A_SC, 8'h0); while (r[7] !== 1'b1);
      apb(0, A_RS, 8'h0);
      chk(r, {24'h0, levels[39:32]});
      levels[39:32] <= 8'h1e;
      repeat (250) @(posedge mclk);
      apb(0, A_RS, 8'h0);
      chk(r, 32'h1e);
      apb(1, A_SC, 8'h1f);
      $display("t_cont done");
   endtask
   // Conversion length for every prescaler code, bus clock first, then the oscillator.
   task automatic t_clock();
      for (int p = 0; p < 8; p++) begin
         div = p > 3 ? 16 : 1 << p;
         apb(1, A_CK, {p[2:0], 5'h10});
         apb(1, A_SC, 8'h41);
         irqwait();
         chk({31'h0, n >= 16 * div - 2 && n <= 17 * div + 6}, 32'h1);
         apb(0, A_RS, 8'h0);
      end
      apb(1, A_CK, 8'h00);
      apb(1, A_SC, 8'h41);
      irqwait();
      chk({31'h0, n >= 120 && n <= 152}, 32'h1);
      apb(0, A_RS, 8'h0);
      chk(r, {24'h0, levels[15:8]});
      $display("t_clock done");
   endtask
   task automatic t_stop();
      apb(1, A_CK, 8'h50);
      apb(1, A_SC, 8'h41);
      repeat (20) @(posedge mclk);
      stop_mode <= 1'b1;
      repeat (150) @(posedge mclk);
      chk({31'h0, conversion_irq}, 32'h0);
      stop_mode <= 1'b0;
      irqwait();
      chk({31'h0, n >= 60 && n <= 80}, 32'h1);
      apb(0, A_RS, 8'h0);
      $display("t_stop done");
   endtask
   task automatic results();
      $display("checks=%0d fails=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Reset, then the scenarios in order.
   initial begin
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      t_reset();
      t_single();
      t_irq();
      t_cont();
      t_clock();
      t_stop();
      results();
   end
endmodule

// ===== rtl/adcsq_pkg.sv
// Constants and types shared by the converter sequencing control block.
package adcsq_pkg;

   // ---------------------------------------------------------------
   // Register byte addresses on the APB side.
   // ---------------------------------------------------------------
   localparam logic [3:0] OFF_STATUS_CONTROL = 4'h0;
   localparam logic [3:0] OFF_RESULT         = 4'h4;
   localparam logic [3:0] OFF_CLOCK_SELECT   = 4'h8;

   // ---------------------------------------------------------------
   // Field positions.
   // ---------------------------------------------------------------
   localparam int DONE_BIT      = 7;
   localparam int IRQ_EN_BIT    = 6;
   localparam int CONT_BIT      = 5;
   localparam int CHAN_MSB      = 4;
   localparam int CHAN_LSB      = 0;
   localparam int PRESCALE_MSB  = 7;
   localparam int PRESCALE_LSB  = 5;
   localparam int SOURCE_BIT    = 4;

   // ---------------------------------------------------------------
   // Reset values.
   // ---------------------------------------------------------------
   localparam logic [4:0] CHAN_RESET     = 5'h1f;
   localparam logic [2:0] PRESCALE_RESET = 3'h0;
   localparam logic       SOURCE_RESET   = 1'b0;

   // ---------------------------------------------------------------
   // Channel codes.
   // ---------------------------------------------------------------
   localparam logic [4:0] CH_EXT_LAST  = 5'h05;
   localparam logic [4:0] CH_REF_HIGH  = 5'h1d;
   localparam logic [4:0] CH_REF_LOW   = 5'h1e;
   localparam logic [4:0] CH_POWER_OFF = 5'h1f;
   localparam int         EXT_CHANNELS = 6;

   // ---------------------------------------------------------------
   // Conversion timing in converter clock ticks: one sample tick plus
   // two ticks per result bit gives 17.
   // ---------------------------------------------------------------
   localparam int         RESULT_BITS    = 8;
   localparam int         CONV_TICKS     = 1 + 2 * RESULT_BITS;
   localparam logic [7:0] SAR_FIRST_TRIAL = 8'h80;
   localparam logic [2:0] SAR_TOP_BIT     = 3'h7;

   // ---------------------------------------------------------------
   // Conversion sequencer states.
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_TRIAL  = 2'b10,
      ST_JUDGE  = 2'b11
   } adcsq_state_t;

endpackage

// ===== rtl/adcsq_top.sv
// Sequencing control for an 8-bit successive approximation converter.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
// Behaviour
// - With interrupt enable set, raise an interrupt after every conversion.
// - With interrupts enabled, done flag is never set and reads zero.
// - Interrupts off: flag set at conversion end, cleared by result read.
// - Interrupt drops on result read or control write; reset clears enable.
// - Continuous bit converts back to back; else one conversion per write.
// - Conversions run on during wait; the interrupt can wake the processor.
// - Stop mode makes the block idle and aborts a running conversion.
// - Conversions resume on leaving stop; software drops the first result.
// - Five-bit channel field; codes zero to five pick external inputs.
// - Code 11101 selects high reference, 11110 selects low reference.
// - All-ones code powers the converter off; first result after is unsettled.
// - Reserved channel codes give an undefined result.
// - One 8-bit result register, written at each conversion end.
// - Prescaler divides by 1, 2, 4, 8, or 16 when its top bit is set.
// - Source bit set picks bus clock, clear picks oscillator clock.
// - A control write starts a conversion lasting 17 converter ticks.
// - Continuous results overwrite the result register unread or not.
// - The selected port pin is claimed as input and reads zero.
module adcsq_top (
   // Clock and reset.
   input  wire logic        mclk,
   input  wire logic        reset,
   // APB slave.
   input  wire logic [3:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // System state and oscillator.
   input  wire logic        stop_mode,
   input  wire logic        oscillator_clock,
   // Analog core.
   input  wire logic        comparator_above,
   output logic      [7:0]  dac_code,
   output logic             sample_hold,
   output logic             converter_power_on,
   output logic      [4:0]  mux_select,
   output logic             select_reference_high,
   output logic             select_reference_low,
   // Shared port pins.
   input  wire logic [5:0]  port_pin_in,
   output logic      [5:0]  analog_pin_claim,
   output logic      [5:0]  port_read_data,
   // Interrupt request.
   output logic             conversion_irq
);

   // ---------------------------------------------------------------
   // Declarations.
   // ---------------------------------------------------------------
   logic                 irq_enable;
   logic                 continuous_convert;
   logic [4:0]           channel_select;
   logic [2:0]           clock_prescale;
   logic                 clock_source_select;
   logic                 conversion_done_flag;
   logic [7:0]           result;
   adcsq_pkg::adcsq_state_t state;
   logic [2:0]           bit_idx;
   logic [3:0]           div_cnt;
   logic [3:0]           div_mask;
   logic                 osc_s1;
   logic                 osc_s2;
   logic                 osc_s3;
   logic                 cmp_s1;
   logic                 cmp_s2;
   logic [5:0]           pin_s1;
   logic [5:0]           pin_s2;
   logic                 stop_q;
   logic                 resume;
   logic                 src_tick;
   logic                 adc_tick;
   logic                 access;
   logic                 wr_scr;
   logic                 wr_clk;
   logic                 rd_res;
   logic                 start;
   logic                 leave_stop;
   logic                 finish;
   logic                 mapped;
   logic [7:0]           read_mux;
   logic [7:0]           judged;

   // ---------------------------------------------------------------
   // Bus decode.
   // ---------------------------------------------------------------
   // A transfer completes at the edge where pready is sampled high.
   assign access = psel & penable & pready;
   assign wr_scr = access & pwrite & (paddr == adcsq_pkg::OFF_STATUS_CONTROL);
   assign wr_clk = access & pwrite & (paddr == adcsq_pkg::OFF_CLOCK_SELECT);
   assign rd_res = access & ~pwrite & (paddr == adcsq_pkg::OFF_RESULT);
   assign mapped = (paddr == adcsq_pkg::OFF_STATUS_CONTROL) |
                   (paddr == adcsq_pkg::OFF_RESULT) |
                   (paddr == adcsq_pkg::OFF_CLOCK_SELECT);

   // Read data; the done flag is masked while interrupts are enabled.
   always_comb begin
      read_mux = 8'h00;
      if (paddr == adcsq_pkg::OFF_STATUS_CONTROL) begin
         read_mux[adcsq_pkg::DONE_BIT] = conversion_done_flag & ~irq_enable;
         read_mux[adcsq_pkg::IRQ_EN_BIT] = irq_enable;
         read_mux[adcsq_pkg::CONT_BIT] = continuous_convert;
         read_mux[adcsq_pkg::CHAN_MSB:adcsq_pkg::CHAN_LSB] = channel_select;
      end else if (paddr == adcsq_pkg::OFF_RESULT) begin
         read_mux = result;
      end else if (paddr == adcsq_pkg::OFF_CLOCK_SELECT) begin
         read_mux[adcsq_pkg::PRESCALE_MSB:adcsq_pkg::PRESCALE_LSB] = clock_prescale;
         read_mux[adcsq_pkg::SOURCE_BIT] = clock_source_select;
      end
   end

   // Every access is answered one cycle into its access phase.
   always_ff @(posedge mclk) begin
      if (reset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped;
         prdata  <= (psel & penable & ~pready & ~pwrite) ? {24'h00_0000, read_mux}
                                                         : 32'h0000_0000;
      end
   end

   // ---------------------------------------------------------------
   // Control registers.
   // ---------------------------------------------------------------
   // The done flag position in write data is ignored.
   always_ff @(posedge mclk) begin
      if (reset) begin
         irq_enable         <= 1'b0;
         continuous_convert <= 1'b0;
         channel_select     <= adcsq_pkg::CHAN_RESET;
      end else if (wr_scr) begin
         irq_enable         <= pwdata[adcsq_pkg::IRQ_EN_BIT];
         continuous_convert <= pwdata[adcsq_pkg::CONT_BIT];
         channel_select     <= pwdata[adcsq_pkg::CHAN_MSB:adcsq_pkg::CHAN_LSB];
      end
   end

   // Clock select register.
   always_ff @(posedge mclk) begin
      if (reset) begin
         clock_prescale      <= adcsq_pkg::PRESCALE_RESET;
         clock_source_select <= adcsq_pkg::SOURCE_RESET;
      end else if (wr_clk) begin
         clock_prescale      <= pwdata[adcsq_pkg::PRESCALE_MSB:adcsq_pkg::PRESCALE_LSB];
         clock_source_select <= pwdata[adcsq_pkg::SOURCE_BIT];
      end
   end

   // ---------------------------------------------------------------
   // Converter clock.
   // ---------------------------------------------------------------
   // The oscillator is foreign to mclk, so only its synchronised copy is
   // edge detected; it must run well below mclk/2 to be seen at all.
   always_ff @(posedge mclk) begin
      if (reset) begin
         osc_s1 <= 1'b0;
         osc_s2 <= 1'b0;
         osc_s3 <= 1'b0;
      end else begin
         osc_s1 <= oscillator_clock;
         osc_s2 <= osc_s1;
         osc_s3 <= osc_s2;
      end
   end

   assign src_tick = clock_source_select | (osc_s2 & ~osc_s3);

   always_comb begin
      unique case (clock_prescale)
         3'h0:    div_mask = 4'h0;
         3'h1:    div_mask = 4'h1;
         3'h2:    div_mask = 4'h3;
         3'h3:    div_mask = 4'h7;
         default: div_mask = 4'hf;
      endcase
   end

   assign adc_tick = src_tick & (div_cnt >= div_mask);

   // Prescaler counter; >= keeps it safe when the ratio shrinks mid-count.
   always_ff @(posedge mclk) begin
      if (reset) begin
         div_cnt <= 4'h0;
      end else if (adc_tick) begin
         div_cnt <= 4'h0;
      end else if (src_tick) begin
         div_cnt <= div_cnt + 4'h1;
      end
   end

   // ---------------------------------------------------------------
   // Conversion sequencer.
   // ---------------------------------------------------------------
   // Comparator output is asynchronous to mclk.
   always_ff @(posedge mclk) begin
      if (reset) begin
         cmp_s1 <= 1'b0;
         cmp_s2 <= 1'b0;
      end else begin
         cmp_s1 <= comparator_above;
         cmp_s2 <= cmp_s1;
      end
   end

   assign start      = wr_scr & (pwdata[adcsq_pkg::CHAN_MSB:adcsq_pkg::CHAN_LSB] !=
                                 adcsq_pkg::CH_POWER_OFF);
   assign leave_stop = stop_q & ~stop_mode;
   assign judged     = cmp_s2 ? dac_code : (dac_code & ~(8'h01 << bit_idx));
   assign finish     = adc_tick & ~stop_mode & ~wr_scr & ~leave_stop &
                       (state == adcsq_pkg::ST_JUDGE) & (bit_idx == 3'h0);

   // Stop entry remembers whether work must resume on exit.
   always_ff @(posedge mclk) begin
      if (reset) begin
         stop_q <= 1'b0;
         resume <= 1'b0;
      end else begin
         stop_q <= stop_mode;
         if (stop_mode & ~stop_q) begin
            resume <= (state != adcsq_pkg::ST_IDLE) | continuous_convert;
         end else if (leave_stop) begin
            resume <= 1'b0;
         end
      end
   end

   // Sample, then one trial and one judge tick per bit: 17 ticks total.
   always_ff @(posedge mclk) begin
      if (reset) begin
         state       <= adcsq_pkg::ST_IDLE;
         dac_code    <= 8'h00;
         bit_idx     <= 3'h0;
         sample_hold <= 1'b0;
      end else if (stop_mode) begin
         state       <= adcsq_pkg::ST_IDLE;
         sample_hold <= 1'b0;
      end else if (wr_scr) begin
         state       <= start ? adcsq_pkg::ST_SAMPLE : adcsq_pkg::ST_IDLE;
         sample_hold <= start;
      end else if (leave_stop & resume & (channel_select != adcsq_pkg::CH_POWER_OFF)) begin
         state       <= adcsq_pkg::ST_SAMPLE;
         sample_hold <= 1'b1;
      end else if (adc_tick) begin
         unique case (state)
            adcsq_pkg::ST_IDLE: begin
               sample_hold <= 1'b0;
            end
            adcsq_pkg::ST_SAMPLE: begin
               sample_hold <= 1'b0;
               dac_code    <= adcsq_pkg::SAR_FIRST_TRIAL;
               bit_idx     <= adcsq_pkg::SAR_TOP_BIT;
               state       <= adcsq_pkg::ST_TRIAL;
            end
            adcsq_pkg::ST_TRIAL: begin
               state <= adcsq_pkg::ST_JUDGE;
            end
            adcsq_pkg::ST_JUDGE: begin
               if (bit_idx == 3'h0) begin
                  dac_code <= judged;
                  state       <= continuous_convert ? adcsq_pkg::ST_SAMPLE
                                                    : adcsq_pkg::ST_IDLE;
                  sample_hold <= continuous_convert;
               end else begin
                  dac_code <= judged | (8'h01 << (bit_idx - 3'h1));
                  bit_idx  <= bit_idx - 3'h1;
                  state    <= adcsq_pkg::ST_TRIAL;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Result, flag and interrupt.
   // ---------------------------------------------------------------
   // result on each completion
   always_ff @(posedge mclk) begin
      if (reset) begin
         result <= 8'h00;
      end else if (finish) begin
         result <= judged;
      end
   end

   // Set wins over a result read in the same cycle.
   always_ff @(posedge mclk) begin
      if (reset) begin
         conversion_done_flag <= 1'b0;
      end else if (finish & ~irq_enable) begin
         conversion_done_flag <= 1'b1;
      end else if (rd_res) begin
         conversion_done_flag <= 1'b0;
      end
   end

   // The request also runs in wait mode, so it can wake the processor.
   always_ff @(posedge mclk) begin
      if (reset) begin
         conversion_irq <= 1'b0;
      end else if (finish & irq_enable) begin
         conversion_irq <= 1'b1;
      end else if (rd_res | wr_scr) begin
         conversion_irq <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Analog selection and port pin claim.
   // ---------------------------------------------------------------
   // channel field to mux
   // reserved codes just pass through, giving no defined result.
   always_ff @(posedge mclk) begin
      if (reset) begin
         mux_select            <= adcsq_pkg::CHAN_RESET;
         converter_power_on    <= 1'b0;
         select_reference_high <= 1'b0;
         select_reference_low  <= 1'b0;
      end else begin
         mux_select            <= channel_select;
         converter_power_on    <= channel_select != adcsq_pkg::CH_POWER_OFF;
         select_reference_high <= channel_select == adcsq_pkg::CH_REF_HIGH;
         select_reference_low  <= channel_select == adcsq_pkg::CH_REF_LOW;
      end
   end

   // Pin levels come from outside and are synchronised first.
   always_ff @(posedge mclk) begin
      if (reset) begin
         pin_s1 <= 6'h00;
         pin_s2 <= 6'h00;
      end else begin
         pin_s1 <= port_pin_in;
         pin_s2 <= pin_s1;
      end
   end

   for (genvar i = 0; i < adcsq_pkg::EXT_CHANNELS; i++) begin : g_pin
      always_ff @(posedge mclk) begin
         if (reset) begin
            analog_pin_claim[i] <= 1'b0;
            port_read_data[i]   <= 1'b0;
         end else begin
            analog_pin_claim[i] <= channel_select == 5'(i);
            port_read_data[i]   <= pin_s2[i] & (channel_select != 5'(i));
         end
      end
   end

endmodule
